// file: design/aio_pkg.sv
/*
 * Shared constants and types for the analog I/O trigger control block.
 * Assumes a single 20 MHz core clock and software writes arriving as
 * one-cycle command words on plain ports.
 */
package aio_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int          NCH        = 6;
    localparam int          DAC_W      = 16;
    localparam int          ADC_W      = 12;
    localparam int          DIV_W      = 7;
    localparam int          MAP_W      = 16;

    // ------------------------------------------------------------------
    // Codes and ranges
    // ------------------------------------------------------------------
    localparam logic [15:0] DAC_ZERO   = 16'h0000;
    localparam logic [15:0] DAC_POS_FS = 16'h7FFF;
    localparam logic [15:0] DAC_NEG_FS = 16'h8000;
    localparam logic [11:0] ADC_MIN    = 12'h000;
    localparam logic [11:0] ADC_MID    = 12'h7D0;
    localparam logic [11:0] ADC_MAX    = 12'hFA0;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          MAP_ENC_LO = 0;
    localparam int          MAP_ADC_LO = 8;
    localparam logic [15:0] MAP_RST    = 16'h0000;
    localparam logic [6:0]  DIV_RST    = 7'h7F;
    localparam logic [11:0] LVL_RST    = 12'hFA0;

    // ------------------------------------------------------------------
    // Bit clock: period = 2 * (div + 1) core cycles
    // ------------------------------------------------------------------
    localparam int          CLK_HZ     = 20_000_000;
    localparam int          HALF_MIN   = 1;
    localparam int          HALF_MAX   = 128;

    typedef enum logic [2:0] {
        AIO_CMD_DAC_VALUE = 3'b000,
        AIO_CMD_OUT_CTRL  = 3'b001,
        AIO_CMD_TRIG_EN   = 3'b010,
        AIO_CMD_TRIG_MAP  = 3'b011,
        AIO_CMD_PRELOAD   = 3'b100,
        AIO_CMD_ADC_LEVEL = 3'b101,
        AIO_CMD_DAC_DIV   = 3'b110,
        AIO_CMD_ADC_DIV   = 3'b111
    } aio_cmd_t;

    typedef struct packed {
        logic        valid;
        aio_cmd_t    cmd;
        logic [2:0]  chan;
        logic [15:0] data;
    } aio_wr_t;

    typedef enum logic [1:0] {
        AIO_S_IDLE  = 2'b00,
        AIO_S_SHIFT = 2'b01,
        AIO_S_GAP   = 2'b10
    } aio_ser_t;

endpackage : aio_pkg

// file: design/aio_dac_ser.sv
/*
 * One DAC serial channel: shifts a 16-bit code out MSB first.
 * Assumes shared bit-clock edge pulses from the top; data changes on
 * the falling edge, the converter samples on the rising edge.
 */
`timescale 1ns/100ps
module aio_dac_ser (
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    input  wire logic                        fall_tick,
    input  wire logic [aio_pkg::DAC_W-1:0]   code,
    output logic                             cs_n,
    output logic                             sdo
);
    import aio_pkg::*;

    aio_ser_t          state_q;
    logic [DAC_W-1:0]  shreg_q;
    logic [4:0]        cnt_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= AIO_S_IDLE;
            shreg_q <= '0;
            cnt_q   <= '0;
            cs_n    <= 1'b1;
            sdo     <= 1'b0;
        end else if (ce && fall_tick) begin
            case (state_q)
                AIO_S_IDLE: begin
                    shreg_q <= {code[DAC_W-2:0], 1'b0};
                    sdo     <= code[DAC_W-1];
                    cs_n    <= 1'b0;
                    cnt_q   <= 5'(DAC_W - 1);
                    state_q <= AIO_S_SHIFT;
                end
                AIO_S_SHIFT: begin
                    if (cnt_q == 5'h00) begin
                        cs_n    <= 1'b1;
                        state_q <= AIO_S_GAP;
                    end else begin
                        sdo     <= shreg_q[DAC_W-1];
                        shreg_q <= {shreg_q[DAC_W-2:0], 1'b0};
                        cnt_q   <= cnt_q - 5'h01;
                    end
                end
                default: begin
                    state_q <= AIO_S_IDLE;
                end
            endcase
        end
    end

endmodule // aio_dac_ser

// file: design/aio_adc_des.sv
/*
 * One ADC serial channel: shifts a 12-bit reading in MSB first.
 * Assumes shared bit-clock edge pulses; samples on the rising edge.
 */
`timescale 1ns/100ps
module aio_adc_des (
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    input  wire logic                        fall_tick,
    input  wire logic                        rise_tick,
    input  wire logic                        sdi,
    output logic                             cs_n,
    output logic                             done,
    output logic [aio_pkg::ADC_W-1:0]        word
);
    import aio_pkg::*;

    aio_ser_t          state_q;
    logic [ADC_W-1:0]  shreg_q;
    logic [3:0]        cnt_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= AIO_S_IDLE;
            shreg_q <= '0;
            cnt_q   <= '0;
            cs_n    <= 1'b1;
            done    <= 1'b0;
            word    <= ADC_MID;
        end else if (ce) begin
            done <= 1'b0;
            case (state_q)
                AIO_S_IDLE: if (fall_tick) begin
                    cs_n    <= 1'b0;
                    cnt_q   <= 4'(ADC_W);
                    state_q <= AIO_S_SHIFT;
                end
                AIO_S_SHIFT: if (rise_tick) begin
                    shreg_q <= {shreg_q[ADC_W-2:0], sdi};
                    cnt_q   <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        word    <= {shreg_q[ADC_W-2:0], sdi};
                        done    <= 1'b1;
                        state_q <= AIO_S_GAP;
                    end
                end
                AIO_S_GAP: if (fall_tick) begin
                    cs_n    <= 1'b1;
                    state_q <= AIO_S_IDLE;
                end
                default: begin
                    state_q <= AIO_S_IDLE;
                end
            endcase
        end
    end

endmodule // aio_adc_des

// file: design/aio_trig_ctrl.sv
/*
 * Top of the analog I/O trigger control: six DAC and six ADC serial
 * channels, per-channel output switch, ADC level comparators and the
 * DAC preload trigger. Assumes software commands arrive as one-cycle
 * words on wr and encoder compare events as one-cycle pulses.
 */
// What this block does
// - DAC codes are 16-bit two's complement
// - ADC readings are 12-bit offset coded
// - Six independent DAC and ADC channels
// - Output switch closes and reopens per channel
// - Trigger enable written per DAC channel
// - Triggers come only from comparator events
// - Mask bits 0-5 encoder, 8-13 ADC
// - Trigger loads preload value onto output
// - ADC compare level 12 bits, 0-4000
// - ADC compare event also standalone interrupt
// - Serial bit clock divided from card clock
// - Separate 0-127 dividers for DAC, ADC
`timescale 1ns/100ps
module aio_trig_ctrl (
    input  wire logic                                        core_clk,
    input  wire logic                                        nrst,
    input  wire logic                                        ce,
    input  wire aio_pkg::aio_wr_t                            wr,
    input  wire logic [aio_pkg::NCH-1:0]                     enc_cmp_evt,
    output logic                                             dac_sclk,
    output logic [aio_pkg::NCH-1:0]                          dac_cs_n,
    output logic [aio_pkg::NCH-1:0]                          dac_sdo,
    output logic [aio_pkg::NCH-1:0]                          dac_out_on,
    output logic                                             adc_sclk,
    output logic [aio_pkg::NCH-1:0]                          adc_cs_n,
    input  wire logic [aio_pkg::NCH-1:0]                     adc_sdi,
    output logic [aio_pkg::NCH-1:0][aio_pkg::ADC_W-1:0]      adc_value,
    output logic [aio_pkg::NCH-1:0]                          adc_cmp_evt,
    output logic [aio_pkg::NCH-1:0][aio_pkg::DAC_W-1:0]      dac_code,
    output logic [aio_pkg::NCH-1:0]                          trig_fired
);
    import aio_pkg::*;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic [NCH-1:0] wr_hit;
    always_comb begin
        wr_hit = '0;
        if (wr.valid && wr.chan < 3'(NCH)) begin
            wr_hit[wr.chan] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Bit clock dividers, one per group
    // ------------------------------------------------------------------
    logic [DIV_W-1:0] dac_div_q;
    logic [DIV_W-1:0] adc_div_q;
    logic [DIV_W-1:0] dac_cnt_q;
    logic [DIV_W-1:0] adc_cnt_q;
    logic             dac_fall;
    logic             dac_rise;
    logic             adc_fall;
    logic             adc_rise;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dac_div_q <= DIV_RST;
            adc_div_q <= DIV_RST;
        end else if (ce && wr.valid) begin
            if (wr.cmd == AIO_CMD_DAC_DIV) begin
                dac_div_q <= wr.data[DIV_W-1:0];
            end
            if (wr.cmd == AIO_CMD_ADC_DIV) begin
                adc_div_q <= wr.data[DIV_W-1:0];
            end
        end
    end

    assign dac_fall = (dac_cnt_q == dac_div_q) && dac_sclk;
    assign dac_rise = (dac_cnt_q == dac_div_q) && !dac_sclk;
    assign adc_fall = (adc_cnt_q == adc_div_q) && adc_sclk;
    assign adc_rise = (adc_cnt_q == adc_div_q) && !adc_sclk;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dac_cnt_q <= '0;
            dac_sclk  <= 1'b1;
        end else if (ce) begin
            if (dac_cnt_q >= dac_div_q) begin
                dac_cnt_q <= '0;
                dac_sclk  <= !dac_sclk;
            end else begin
                dac_cnt_q <= dac_cnt_q + 7'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            adc_cnt_q <= '0;
            adc_sclk  <= 1'b1;
        end else if (ce) begin
            if (adc_cnt_q >= adc_div_q) begin
                adc_cnt_q <= '0;
                adc_sclk  <= !adc_sclk;
            end else begin
                adc_cnt_q <= adc_cnt_q + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-channel state
    // ------------------------------------------------------------------
    logic [NCH-1:0][DAC_W-1:0] preload_q;
    logic [NCH-1:0][MAP_W-1:0] map_q;
    logic [NCH-1:0][ADC_W-1:0] level_q;
    logic [NCH-1:0]            trig_en_q;
    logic [NCH-1:0]            above_q;
    logic [NCH-1:0]            adc_done;
    logic [NCH-1:0][ADC_W-1:0] adc_word;
    logic [NCH-1:0][DAC_W-1:0] ser_code;
    logic [NCH-1:0]            trig_hit;
    logic [2*NCH+3:0]          src_vec;

    // Sources laid out as the mask: encoder at bit 0, ADC at bit 8
    always_comb begin
        src_vec = '0;
        src_vec[MAP_ENC_LO +: NCH] = enc_cmp_evt;
        src_vec[MAP_ADC_LO +: NCH] = adc_cmp_evt;
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch

            // Config registers written by software
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    preload_q[ch] <= DAC_ZERO;
                    map_q[ch]     <= MAP_RST;
                    level_q[ch]   <= LVL_RST;
                    trig_en_q[ch] <= 1'b0;
                end else if (ce && wr_hit[ch]) begin
                    case (wr.cmd)
                        AIO_CMD_PRELOAD:   preload_q[ch] <= wr.data;
                        AIO_CMD_TRIG_MAP:  map_q[ch]     <= wr.data;
                        AIO_CMD_TRIG_EN:   trig_en_q[ch] <= wr.data[0];
                        AIO_CMD_ADC_LEVEL: begin
                            // Clamp to the valid reading span
                            level_q[ch] <= (wr.data[ADC_W-1:0] > ADC_MAX) ?
                                           ADC_MAX : wr.data[ADC_W-1:0];
                        end
                        default: begin
                        end
                    endcase
                end
            end

            // Any enabled source fires the channel
            assign trig_hit[ch] = trig_en_q[ch] &&
                                  |(map_q[ch][2*NCH+3:0] & src_vec);

            // Output code: trigger wins over a same-cycle value write
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    dac_code[ch]   <= DAC_ZERO;
                    trig_fired[ch] <= 1'b0;
                end else if (ce) begin
                    trig_fired[ch] <= trig_hit[ch];
                    if (trig_hit[ch]) begin
                        dac_code[ch] <= preload_q[ch];
                    end else if (wr_hit[ch] && wr.cmd == AIO_CMD_DAC_VALUE) begin
                        dac_code[ch] <= wr.data;
                    end
                end
            end

            // Output switch, closed until opened by software
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    dac_out_on[ch] <= 1'b0;
                end else if (ce && wr_hit[ch] && wr.cmd == AIO_CMD_OUT_CTRL) begin
                    dac_out_on[ch] <= wr.data[0];
                end
            end

            // Closed channel sends mid-scale zero volts and stays switched off
            assign ser_code[ch] = dac_out_on[ch] ? dac_code[ch] : DAC_ZERO;

            aio_dac_ser u_dac (
                .core_clk  (core_clk),
                .nrst      (nrst),
                .ce        (ce),
                .fall_tick (dac_fall),
                .code      (ser_code[ch]),
                .cs_n      (dac_cs_n[ch]),
                .sdo       (dac_sdo[ch])
            );

            aio_adc_des u_adc (
                .core_clk  (core_clk),
                .nrst      (nrst),
                .ce        (ce),
                .fall_tick (adc_fall),
                .rise_tick (adc_rise),
                .sdi       (adc_sdi[ch]),
                .cs_n      (adc_cs_n[ch]),
                .done      (adc_done[ch]),
                .word      (adc_word[ch])
            );

            // Reading capture and upward level crossing
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    adc_value[ch]   <= ADC_MID;
                    above_q[ch]     <= 1'b1;
                    adc_cmp_evt[ch] <= 1'b0;
                end else if (ce) begin
                    adc_cmp_evt[ch] <= 1'b0;
                    if (adc_done[ch]) begin
                        adc_value[ch] <= adc_word[ch];
                        above_q[ch]   <= adc_word[ch] >= level_q[ch];
                        adc_cmp_evt[ch] <= !above_q[ch] &&
                                           (adc_word[ch] >= level_q[ch]);
                    end
                end
            end
        end
    endgenerate

endmodule // aio_trig_ctrl

// file: tb/aio_trig_monitor.sv
/*
 * Port checker for aio_trig_ctrl.
 * Assumes it is bound to the top and sees one core clock domain.
 */
`timescale 1ns/100ps
module aio_trig_monitor (
    input wire logic                                   core_clk,
    input wire logic                                   nrst,
    input wire logic                                   ce,
    input wire aio_pkg::aio_wr_t                       wr,
    input wire logic [aio_pkg::NCH-1:0]                enc_cmp_evt,
    input wire logic [aio_pkg::NCH-1:0]                dac_cs_n,
    input wire logic [aio_pkg::NCH-1:0]                dac_sdo,
    input wire logic [aio_pkg::NCH-1:0]                dac_out_on,
    input wire logic [aio_pkg::NCH-1:0][11:0]          adc_value,
    input wire logic [aio_pkg::NCH-1:0]                adc_cmp_evt,
    input wire logic [aio_pkg::NCH-1:0][15:0]          dac_code,
    input wire logic [aio_pkg::NCH-1:0]                trig_fired
);
    import aio_pkg::*;
    logic        wr0;
    logic [15:0] pre0_q;
    logic [11:0] lvl0_q;
    logic [12:0] low0_q;
    assign wr0 = ce && wr.valid && wr.chan == 3'h0;
    // --------
    // Shadow of channel 0 settings
    // --------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) pre0_q <= 16'h0000;
        else if (wr0 && wr.cmd == AIO_CMD_PRELOAD) pre0_q <= wr.data;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) lvl0_q <= LVL_RST;
        else if (wr0 && wr.cmd == AIO_CMD_ADC_LEVEL)
            lvl0_q <= (wr.data[11:0] > ADC_MAX) ? ADC_MAX : wr.data[11:0];
    end
    // Core cycles spent with channel 0 frame select low
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) low0_q <= 13'h0000;
        else if (dac_cs_n[0]) low0_q <= 13'h0000;
        else if (ce && low0_q != 13'h1FFF) low0_q <= low0_q + 13'h0001;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_frame_low;
        !dac_cs_n[0] [*8];
    endsequence
    chk_value_write: assert property (
        (wr0 && wr.cmd == AIO_CMD_DAC_VALUE && enc_cmp_evt == '0 && adc_cmp_evt == '0)
        |=> dac_code[0] == $past(wr.data)) else $error("dac code not written");
    chk_out_switch: assert property (
        (ce && wr.valid && wr.cmd == AIO_CMD_OUT_CTRL && wr.chan < 3'h6)
        |=> dac_out_on[$past(wr.chan)] == $past(wr.data[0])) else $error("switch wrong");
    chk_closed_zero: assert property (
        $fell(dac_cs_n[0]) && !$past(dac_out_on[0]) |-> !dac_sdo[0])
        else $error("closed channel sends data");
    chk_trig_source: assert property (
        trig_fired != '0 |-> $past(enc_cmp_evt != '0 || adc_cmp_evt != '0))
        else $error("trigger without event");
    chk_trig_preload: assert property (
        trig_fired[0] |-> dac_code[0] == pre0_q) else $error("trigger code wrong");
    chk_cmp_level: assert property (
        adc_cmp_evt[0] |-> adc_value[0] >= lvl0_q) else $error("event below level");
    chk_evt_single: assert property (
        adc_cmp_evt[0] |=> !adc_cmp_evt[0] [*8]) else $error("event not a pulse");
    chk_frame_len: assert property (
        $fell(dac_cs_n[0]) |-> s_frame_low) else $error("dac frame too short");
    chk_frame_count: assert property (
        $rose(dac_cs_n[0]) |-> low0_q >= 13'h0020 && low0_q <= 13'h1000)
        else $error("dac frame length wrong");
endmodule // aio_trig_monitor

// file: tb/aio_conv_model.sv
/*
 * Behavioural six-channel serial DAC and ADC converters.
 * Assumes adc_smp is set by the testbench; dac_rx holds the last word.
 */
`timescale 1ns/100ps
module aio_conv_model (
    input wire logic                                 core_clk,
    input wire logic                                 dac_sclk,
    input wire logic [aio_pkg::NCH-1:0]              dac_cs_n,
    input wire logic [aio_pkg::NCH-1:0]              dac_sdo,
    input wire logic                                 adc_sclk,
    input wire logic [aio_pkg::NCH-1:0]              adc_cs_n,
    input wire logic [aio_pkg::NCH-1:0][11:0]        adc_smp,
    output logic [aio_pkg::NCH-1:0]                  adc_sdi,
    output logic [aio_pkg::NCH-1:0][15:0]            dac_rx
);
    import aio_pkg::*;
    logic                 ds_q;
    logic                 as_q;
    logic [NCH-1:0]       cs_q;
    logic [NCH-1:0][15:0] sh_q;
    logic [NCH-1:0][3:0]  idx_q;
    always @(posedge core_clk) begin
        ds_q <= dac_sclk;
        as_q <= adc_sclk;
        cs_q <= dac_cs_n;
        for (int c = 0; c < NCH; c++) begin
            if (dac_sclk && !ds_q && !dac_cs_n[c]) sh_q[c] <= {sh_q[c][14:0], dac_sdo[c]};
            if (dac_cs_n[c] && !cs_q[c]) dac_rx[c] <= sh_q[c];
            if (adc_cs_n[c]) idx_q[c] <= 4'h0;
            else if (adc_sclk && !as_q) idx_q[c] <= idx_q[c] + 4'h1;
        end
    end
    // Released line shows the inverse of the last bit sent
    always_comb begin
        for (int c = 0; c < NCH; c++)
            adc_sdi[c] = (adc_cs_n[c] || idx_q[c] > 4'hB) ? ~adc_smp[c][0]
                       : adc_smp[c][4'hB - idx_q[c]];
    end
endmodule // aio_conv_model

// file: tb/tb.sv
/*
 * Self-checking testbench for aio_trig_ctrl.
 * Assumes the converter model and the checker files are compiled first.
 */
`timescale 1ns/100ps
module tb;
    import aio_pkg::*;
    logic                      core_clk = 1'b0;
    logic                      nrst = 1'b0;
    logic                      ce = 1'b1;
    aio_wr_t                   wr = '0;
    logic [NCH-1:0]            enc_cmp_evt = '0;
    logic                      dac_sclk;
    logic                      adc_sclk;
    logic [NCH-1:0]            dac_cs_n, dac_sdo, dac_out_on, adc_cs_n, adc_sdi;
    logic [NCH-1:0]            adc_cmp_evt, trig_fired;
    logic [NCH-1:0][11:0]      adc_value;
    logic [NCH-1:0][11:0]      smp = '0;
    logic [NCH-1:0][15:0]      dac_code;
    logic [NCH-1:0][15:0]      rx;
    int                        err_count = 0;
    int                        comparisons = 0;
    int                        ev0, ev1, tf0;
    always #25 core_clk = ~core_clk;
    aio_trig_ctrl dut (.core_clk, .nrst, .ce, .wr, .enc_cmp_evt, .dac_sclk, .dac_cs_n,
        .dac_sdo, .dac_out_on, .adc_sclk, .adc_cs_n, .adc_sdi, .adc_value, .adc_cmp_evt,
        .dac_code, .trig_fired);
    aio_conv_model mdl (.core_clk, .dac_sclk, .dac_cs_n, .dac_sdo, .adc_sclk, .adc_cs_n,
        .adc_smp(smp), .adc_sdi, .dac_rx(rx));
    // --------
    // Shared tasks
    // --------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic put(input aio_cmd_t c, input logic [2:0] ch, input logic [15:0] d);
        wr = '{1'b1, c, ch, d};
        cyc(1);
        wr.valid = 1'b0;
        cyc(1);
    endtask
    task automatic wait_val(input bit a, input int c, input logic [15:0] e);
        int n = 0;
        while ((a ? {4'h0, adc_value[c]} : rx[c]) !== e && n < 600) begin
            cyc(1);
            n++;
        end
        chk(a ? "adc value" : "wire code", a ? {4'h0, adc_value[c]} : rx[c], e);
        if (n == 600) test_done();
    endtask
    task automatic watch(input int n);
        ev0 = 0;
        ev1 = 0;
        tf0 = 0;
        repeat (n) begin
            if (adc_cmp_evt[0] === 1'b1) ev0++;
            if (adc_cmp_evt[1] === 1'b1) ev1++;
            if (trig_fired[0] === 1'b1) tf0++;
            cyc(1);
        end
    endtask
    task automatic pulse(input logic [5:0] m, input int n);
        enc_cmp_evt = m;
        cyc(1);
        enc_cmp_evt = '0;
        watch(4);
        chk("trigger count", tf0[15:0], n[15:0]);
    endtask
    task automatic per(input bit a, input int e);
        int n = 0;
        int f = 0;
        int s = 0;
        int t = 0;
        logic c = 1'b1;
        while (t == 0 && n < 12000) begin
            cyc(1);
            n++;
            if (f == 2 && (a ? adc_sclk : dac_sclk) === 1'b1) t = n - s;
            if ((a ? adc_cs_n[0] : dac_cs_n[0]) === 1'b0 && c === 1'b1) begin
                f++;
                s = n;
            end
            c = a ? adc_cs_n[0] : dac_cs_n[0];
        end
        chk("sclk low time", t[15:0], e[15:0]);
        if (n == 12000) test_done();
    endtask
    // --------
    // Scenarios
    // --------
    task automatic t_div;
        logic [6:0] dv [3] = '{7'h7F, 7'h03, 7'h00};
        chk("reset code", dac_code[0], DAC_ZERO);
        chk("reset adc", {4'h0, adc_value[0]}, {4'h0, ADC_MID});
        foreach (dv[i]) begin
            put(AIO_CMD_DAC_DIV, 3'h0, {9'h000, dv[i]});
            put(AIO_CMD_ADC_DIV, 3'h0, {9'h000, dv[i]});
            per(1'b0, dv[i] + 1);
            per(1'b1, dv[i] + 1);
        end
        $display("divider test done");
    endtask
    task automatic t_dac;
        logic [15:0] cd [6] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h1234, 16'hFFFF, 16'h0001};
        logic        sk;
        for (int c = 0; c < NCH; c++) begin
            put(AIO_CMD_OUT_CTRL, c[2:0], 16'h0001);
            put(AIO_CMD_DAC_VALUE, c[2:0], cd[c]);
            chk("dac code", dac_code[c], cd[c]);
        end
        for (int c = 0; c < NCH; c++) wait_val(1'b0, c, cd[c]);
        put(AIO_CMD_OUT_CTRL, 3'h2, 16'h0000);
        chk("switch", {15'h0000, dac_out_on[2]}, 16'h0000);
        wait_val(1'b0, 2, DAC_ZERO);
        put(AIO_CMD_OUT_CTRL, 3'h2, 16'h0001);
        wait_val(1'b0, 2, cd[2]);
        put(AIO_CMD_DAC_VALUE, 3'h6, 16'h5555);
        chk("dac code", dac_code[5], cd[5]);
        // Clock enable low must freeze writes and the bit clock
        sk = dac_sclk;
        ce = 1'b0;
        put(AIO_CMD_DAC_VALUE, 3'h3, 16'h0F0F);
        chk("frozen code", dac_code[3], cd[3]);
        chk("frozen sclk", {15'h0000, dac_sclk}, {15'h0000, sk});
        ce = 1'b1;
        $display("dac test done");
    endtask
    task automatic t_adc;
        logic [11:0] av [6] = '{12'h000, 12'h7D0, 12'hFA0, 12'h001, 12'hF9F, 12'h555};
        for (int c = 0; c < NCH; c++) smp[c] = av[c];
        for (int c = 0; c < NCH; c++) wait_val(1'b1, c, {4'h0, av[c]});
        put(AIO_CMD_ADC_LEVEL, 3'h0, 16'h03E8);
        smp[0] = 12'h1F4;
        wait_val(1'b1, 0, 16'h01F4);
        smp[0] = 12'hBB8;
        watch(150);
        chk("level events", ev0[15:0], 16'h0001);
        put(AIO_CMD_ADC_LEVEL, 3'h0, 16'h0FFF);
        smp[0] = 12'h000;
        wait_val(1'b1, 0, 16'h0000);
        smp[0] = 12'hFA0;
        watch(150);
        chk("clamped events", ev0[15:0], 16'h0001);
        $display("adc test done");
    endtask
    task automatic t_trig;
        put(AIO_CMD_PRELOAD, 3'h0, 16'hA5A5);
        put(AIO_CMD_TRIG_MAP, 3'h0, 16'h0204);
        put(AIO_CMD_TRIG_EN, 3'h0, 16'h0001);
        pulse(6'h08, 0);
        pulse(6'h04, 1);
        chk("dac code", dac_code[0], 16'hA5A5);
        put(AIO_CMD_DAC_VALUE, 3'h0, 16'h0000);
        put(AIO_CMD_ADC_LEVEL, 3'h1, 16'h03E8);
        smp[1] = 12'h1F4;
        wait_val(1'b1, 1, 16'h01F4);
        smp[1] = 12'hBB8;
        watch(150);
        chk("adc trigger", tf0[15:0], 16'h0001);
        chk("adc event", ev1[15:0], 16'h0001);
        chk("dac code", dac_code[0], 16'hA5A5);
        put(AIO_CMD_TRIG_EN, 3'h0, 16'h0000);
        pulse(6'h04, 0);
        put(AIO_CMD_TRIG_EN, 3'h0, 16'h0001);
        put(AIO_CMD_OUT_CTRL, 3'h0, 16'h0000);
        wr = '{1'b1, AIO_CMD_DAC_VALUE, 3'h0, 16'h1111};
        enc_cmp_evt = 6'h04;
        cyc(1);
        wr.valid = 1'b0;
        enc_cmp_evt = '0;
        chk("dac code", dac_code[0], 16'hA5A5);
        chk("switch", {15'h0000, dac_out_on[0]}, 16'h0000);
        wait_val(1'b0, 0, DAC_ZERO);
        put(AIO_CMD_OUT_CTRL, 3'h0, 16'h0001);
        wait_val(1'b0, 0, 16'hA5A5);
        $display("trigger test done");
    endtask
    initial begin
        cyc(10);
        nrst = 1'b1;
        t_div;
        t_dac;
        t_adc;
        t_trig;
        test_done;
    end
endmodule // tb
bind aio_trig_ctrl aio_trig_monitor mon (.core_clk, .nrst, .ce, .wr, .enc_cmp_evt,
    .dac_cs_n, .dac_sdo, .dac_out_on, .adc_value, .adc_cmp_evt, .dac_code, .trig_fired);
